/* hdl/dgc_top.sv */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`include "dgc_defines.svh"
module dgc_top (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // avalon-mm register slave
    input  wire logic [7:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // record sample stream
    input  wire logic [15:0] SMP_DATA_IN,
    input  wire logic        SMP_VALID_IN,
    output logic      [15:0] SMP_DATA_OUT,
    output logic             SMP_VALID_OUT,
    output logic      [31:0] GAIN_OUT
);
    // byte lane merge of a write
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        merge = old;
        if (be[0]) begin
            merge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge[15:8] = wd[15:8];
        end
    endfunction

    // index of the highest set bit
    function automatic logic [4:0] msb_pos(input logic [31:0] v);
        msb_pos = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                msb_pos = 5'(i);
            end
        end
    endfunction

    logic [15:0]            main_q;
    logic [15:0]            dyn_q;
    logic                   wait_q;
    logic [31:0]            rdata_q;
    logic [31:0]            ms_q;
    logic [31:0]            pk_q;
    logic [15:0]            out_q;
    logic                   vld_q;
    dgc_pkg::dgc_gain_type  gain_q;
    dgc_pkg::dgc_gain_type  app_q;
    dgc_pkg::dgc_state_type state_q;

    // bus decode and answer
    wire        req      = AVS_READ_IN | AVS_WRITE_IN;
    wire        ack      = req & ~wait_q;
    wire [7:0]  main_adr = `DGC_IDX_MAIN * 8'h04;
    wire [7:0]  dyn_adr  = `DGC_IDX_DYN * 8'h04;
    wire        sel_main = AVS_ADDRESS_IN == main_adr;
    wire        sel_dyn  = AVS_ADDRESS_IN == dyn_adr;
    wire        wr_ack   = ack & AVS_WRITE_IN;
    wire [15:0] main_d   = (wr_ack & sel_main)
        ? merge(main_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
          & `DGC_MAIN_MASK
        : main_q;
    wire [15:0] dyn_d    = (wr_ack & sel_dyn)
        ? merge(dyn_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
        : dyn_q;
    wire [31:0] rd_mux   = sel_main ? {16'h0000, main_q}
                         : sel_dyn  ? {16'h0000, dyn_q}
                         : 32'h0000_0000;
    wire [31:0] rdata_d  = (req & wait_q) ? rd_mux : rdata_q;

    // register file and wait state
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            main_q  <= `DGC_MAIN_RST;
            dyn_q   <= `DGC_DYN_RST;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            main_q  <= main_d;
            dyn_q   <= dyn_d;
            wait_q  <= ~(req & wait_q);
            rdata_q <= rdata_d;
        end
    end

    // control fields
    wire       en_bit    = main_q[`DGC_EN_BIT];
    wire       guard_en  = main_q[`DGC_GUARD_BIT];
    wire       look_long = main_q[`DGC_LOOK_BIT];
    wire       fast_en   = main_q[`DGC_FAST_BIT];
    wire       smooth_en = main_q[`DGC_SMOOTH_BIT];
    wire       hyst_en   = main_q[`DGC_HYST_BIT];
    wire [1:0] hyst_raw  = main_q[`DGC_HYSTL_HI:`DGC_HYSTL_LO];
    wire [4:0] init_raw  = main_q[`DGC_INIT_HI:`DGC_INIT_LO];
    wire [3:0] fall_raw  = dyn_q[`DGC_FALL_HI:`DGC_FALL_LO];
    wire [3:0] rise_raw  = dyn_q[`DGC_RISE_HI:`DGC_RISE_LO];
    wire [1:0] crest_c   = dyn_q[`DGC_CREST_HI:`DGC_CREST_LO];
    wire [1:0] frate_raw = dyn_q[`DGC_FRATE_HI:`DGC_FRATE_LO];
    wire [1:0] floor_c   = dyn_q[`DGC_FLOOR_HI:`DGC_FLOOR_LO];
    wire [1:0] ceil_c    = dyn_q[`DGC_CEIL_HI:`DGC_CEIL_LO];
    wire       run       = state_q == dgc_pkg::ST_RUN;

    // reserved codes folded to the nearest defined one
    wire [3:0] fall_c  = (fall_raw == 4'h0) ? 4'h1
                       : (fall_raw > `DGC_FALL_MAX) ? `DGC_FALL_MAX
                       : fall_raw;
    wire [3:0] rise_c  = (rise_raw > `DGC_RISE_MAX) ? `DGC_RISE_MAX
                       : rise_raw;
    wire [1:0] frate_c = (frate_raw == 2'h3) ? 2'h2 : frate_raw;
    wire [1:0] hyst_c  = (hyst_raw == 2'h3) ? 2'h2 : hyst_raw;
    wire [4:0] init_c  = (init_raw > `DGC_INIT_MAX) ? `DGC_INIT_MAX
                       : init_raw;

    // per-sample step sizes, each fall and rise code doubles the time
    wire [31:0] fall_step = `DGC_STEP(`DGC_FALL_T0_NS)
                            >> (fall_c - 4'h1);
    wire [31:0] dec_step  = `DGC_STEP(`DGC_RISE_T0_NS)
                            >> rise_c;
    wire [31:0] qr_step   = (frate_c == 2'h0)
                            ? `DGC_STEP(`DGC_FAST_T0_NS)
                            : (frate_c == 2'h1)
                            ? `DGC_STEP(`DGC_FAST_T1_NS)
                            : `DGC_STEP(`DGC_FAST_T2_NS);

    // limits and initial gain
    wire [2:0]         ceil_oct = (ceil_c == 2'h3) ? 3'h6
                                : {1'b0, ceil_c} + 3'h2;
    wire signed [31:0] floor_g  = -$signed({6'h00, floor_c, 24'h0});
    wire signed [31:0] ceil_g   = $signed({5'h00, ceil_oct, 24'h0});
    wire signed [31:0] init_g   = ($signed({27'h0, init_c})
                                   - 32'sh6) <<< 23;

    // mean square and decaying peak of the input
    wire signed [15:0] x_in = SMP_DATA_IN;
    wire [31:0] sq   = 32'($signed(x_in) * $signed(x_in));
    wire [31:0] ms_d = ms_q - (ms_q >> `DGC_MS_SH)
                       + (sq >> `DGC_MS_SH);
    wire [31:0] pk_d = (sq > pk_q) ? sq
                       : pk_q - (pk_q >> `DGC_PK_SH);
    wire [4:0]  lvl  = msb_pos(ms_q);
    wire [4:0]  pkl  = msb_pos(pk_q);
    wire [4:0]  inl  = msb_pos(sq);

    // level error against target, in log2 of power
    wire signed [7:0] g_int = gain_q[31:24];
    wire signed [9:0] g2    = {g_int[7], g_int, 1'b0};
    wire signed [9:0] err   = $signed({5'h00, lvl}) + g2
                              - `DGC_TARGET_L2;
    wire signed [9:0] hyst  = hyst_en ? (10'sh001 <<< hyst_c)
                                      : 10'sh000;
    wire go_dn = err > hyst;
    wire go_up = err < -hyst;

    // early clip risk from the undelayed input
    wire clip_risk = guard_en
        & (($signed({5'h00, inl}) + g2) >= `DGC_CLIP_L2);
    wire [31:0] fall_eff = clip_risk ? (fall_step << 2) : fall_step;

    // crest factor test, threshold 12 dB plus 6 dB per code
    wire [5:0] crest_thr = {3'h0, crest_c, 1'b0} + 6'h04;
    wire crest_hit = fast_en
        & ({1'b0, pkl} >= ({1'b0, lvl} + crest_thr));
    wire [31:0] rise_step = crest_hit ? qr_step : dec_step;

    // next gain with clamping
    wire signed [31:0] stepped = go_dn ? gain_q - $signed(fall_eff)
                               : go_up ? gain_q + $signed(rise_step)
                               : gain_q;
    wire signed [31:0] clamped = (stepped < floor_g) ? floor_g
                               : (stepped > ceil_g) ? ceil_g
                               : stepped;
    wire signed [31:0] app_next = smooth_en
        ? app_q + ((gain_q - app_q) >>> `DGC_SMOOTH_SH)
        : gain_q;

    // state, gain and detector registers
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q <= dgc_pkg::ST_OFF;
            gain_q  <= 32'sh0;
            app_q   <= 32'sh0;
            ms_q    <= 32'h0;
            pk_q    <= 32'h0;
        end else begin
            case (state_q)
                dgc_pkg::ST_OFF: begin
                    gain_q <= init_g;
                    app_q  <= init_g;
                    ms_q   <= 32'h0;
                    pk_q   <= 32'h0;
                    if (en_bit) begin
                        state_q <= dgc_pkg::ST_RUN;
                    end
                end
                dgc_pkg::ST_RUN: begin
                    if (!en_bit) begin
                        state_q <= dgc_pkg::ST_OFF;
                    end else if (SMP_VALID_IN) begin
                        gain_q <= clamped;
                        app_q  <= app_next;
                        ms_q   <= ms_d;
                        pk_q   <= pk_d;
                    end
                end
                default: begin
                    state_q <= dgc_pkg::ST_OFF;
                end
            endcase
        end
    end

    // look-ahead delay line
    dgc_smp_if in_if ();
    dgc_smp_if dl_if ();
    assign in_if.data  = SMP_DATA_IN;
    assign in_if.valid = SMP_VALID_IN;

    dgc_lookahead u_look (
        .clk_in  (CLK_IN),
        .rst_in  (RST_IN),
        .long_in (look_long),
        .en_in   (guard_en & run),
        .src     (in_if),
        .dst     (dl_if)
    );

    // gain apply: power of two shift times mantissa
    wire signed [7:0]  a_int = app_q[31:24];
    wire        [7:0]  a_neg = 8'(-a_int);
    wire signed [9:0]  mant  = {2'b01, app_q[23:16]};
    wire signed [39:0] prod  = 40'(dl_if.data * mant);
    wire signed [39:0] shf   = a_int[7] ? (prod >>> a_neg)
                                        : (prod <<< a_int);
    wire signed [39:0] y     = shf >>> 8;
    wire [15:0] y_sat = (y > 40'sh7FFF) ? 16'h7FFF
                      : (y < -40'sh8000) ? 16'h8000
                      : y[15:0];
    wire [15:0] out_d = !SMP_VALID_IN ? out_q
                      : run ? y_sat : SMP_DATA_IN;

    // output registers
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            out_q <= 16'h0000;
            vld_q <= 1'b0;
        end else begin
            out_q <= out_d;
            vld_q <= SMP_VALID_IN;
        end
    end

    assign AVS_READDATA_OUT    = rdata_q;
    assign AVS_WAITREQUEST_OUT = wait_q;
    assign SMP_DATA_OUT        = out_q;
    assign SMP_VALID_OUT       = vld_q;
    assign GAIN_OUT            = app_q;

    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_floor;
        run && en_bit && SMP_VALID_IN |=> gain_q >= $past(floor_g);
    endproperty
    a_floor: assert property (p_floor) else $error("gain below floor");

    property p_ceil;
        run && en_bit && SMP_VALID_IN |=> gain_q <= $past(ceil_g);
    endproperty
    a_ceil: assert property (p_ceil) else $error("gain above ceiling");

    property p_fall;
        run && en_bit && SMP_VALID_IN && go_dn && !clip_risk
        && (gain_q - $signed(fall_step) >= floor_g)
        && (gain_q - $signed(fall_step) <= ceil_g)
        |=> gain_q == $past(gain_q) - $signed($past(fall_step));
    endproperty
    a_fall: assert property (p_fall) else $error("attack step wrong");

    property p_rise;
        run && en_bit && SMP_VALID_IN && go_up && !crest_hit
        && (gain_q + $signed(dec_step) <= ceil_g)
        && (gain_q + $signed(dec_step) >= floor_g)
        |=> gain_q == $past(gain_q) + $signed($past(dec_step));
    endproperty
    a_rise: assert property (p_rise) else $error("decay step wrong");

    property p_fast;
        run && en_bit && SMP_VALID_IN && go_up && crest_hit
        && (gain_q + $signed(qr_step) <= ceil_g)
        && (gain_q + $signed(qr_step) >= floor_g)
        |=> gain_q == $past(gain_q) + $signed($past(qr_step));
    endproperty
    a_fast: assert property (p_fast) else $error("fast step wrong");

    property p_hold;
        run && en_bit && !SMP_VALID_IN |=> $stable(gain_q);
    endproperty
    a_hold: assert property (p_hold) else $error("gain moved");

    property p_bypass;
        !run && SMP_VALID_IN |=> SMP_DATA_OUT == $past(SMP_DATA_IN);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass bad");

    property p_nodelay;
        run && !guard_en && app_q == 32'sh0 && SMP_VALID_IN
        |=> SMP_DATA_OUT == $past(SMP_DATA_IN);
    endproperty
    a_nodelay: assert property (p_nodelay) else $error("delay seen");

    property p_start;
        state_q == dgc_pkg::ST_OFF |=> gain_q == $past(init_g);
    endproperty
    a_start: assert property (p_start) else $error("bad start gain");

    property p_codes;
        fall_c >= 4'h1 && fall_c <= `DGC_FALL_MAX
        && rise_c <= `DGC_RISE_MAX && frate_c != 2'h3;
    endproperty
    a_codes: assert property (p_codes) else $error("code unfolded");

    property p_wr;
        wr_ack && sel_main && AVS_BYTEENABLE_IN[1:0] == 2'h3
        |=> main_q == ($past(AVS_WRITEDATA_IN[15:0]) & `DGC_MAIN_MASK);
    endproperty
    a_wr: assert property (p_wr) else $error("write lost");

    c_crest: cover property (run && SMP_VALID_IN && go_up && crest_hit);
    c_clip:  cover property (run && SMP_VALID_IN && clip_risk);
    c_floor: cover property (run && gain_q == floor_g && floor_c != 2'h0);
    c_write: cover property (wr_ack && sel_dyn);
endmodule

/* hdl/dgc_defines.svh */
`ifndef DGC_DEFINES_SVH
`define DGC_DEFINES_SVH
// register indices; byte address is four times the index
`define DGC_IDX_MAIN   8'h28
`define DGC_IDX_DYN    8'h29
`define DGC_MAIN_RST   16'h09AF
`define DGC_DYN_RST    16'h3241
`define DGC_MAIN_MASK  16'h9FEF
// main register fields
`define DGC_EN_BIT     15
`define DGC_HYSTL_HI   12
`define DGC_HYSTL_LO   11
`define DGC_INIT_HI    10
`define DGC_INIT_LO    6
`define DGC_LOOK_BIT   5
`define DGC_SMOOTH_BIT 3
`define DGC_FAST_BIT   2
`define DGC_GUARD_BIT  1
`define DGC_HYST_BIT   0
// dynamics register fields
`define DGC_FALL_HI    15
`define DGC_FALL_LO    12
`define DGC_RISE_HI    11
`define DGC_RISE_LO    8
`define DGC_CREST_HI   7
`define DGC_CREST_LO   6
`define DGC_FRATE_HI   5
`define DGC_FRATE_LO   4
`define DGC_FLOOR_HI   3
`define DGC_FLOOR_LO   2
`define DGC_CEIL_HI    1
`define DGC_CEIL_LO    0
// highest defined codes
`define DGC_FALL_MAX   4'hA
`define DGC_RISE_MAX   4'h8
`define DGC_INIT_MAX   5'h12
// look-ahead line: tap index n delays by n+1 samples
`define DGC_LINE_LEN   9
`define DGC_TAP_SHORT  4
`define DGC_TAP_LONG   8
// sample rate and rate times per 6 dB
`define DGC_FS_HZ      64'd48000
`define DGC_GAIN_6DB   64'h1000000
`define DGC_FALL_T0_NS 64'd182000
`define DGC_RISE_T0_NS 64'd186000000
`define DGC_FAST_T0_NS 64'd725000
`define DGC_FAST_T1_NS 64'd1450000
`define DGC_FAST_T2_NS 64'd5800000
// per-sample gain step for a time per 6 dB
`define DGC_STEP(t) (32'((`DGC_GAIN_6DB * 64'd1000000000) / ((t) * `DGC_FS_HZ)))
// level loop constants: levels in log2 of squared amplitude, then shift amounts
`define DGC_TARGET_L2  10'sh01A
`define DGC_CLIP_L2    10'sh01E
`define DGC_MS_SH      6
`define DGC_PK_SH      10
`define DGC_SMOOTH_SH  4
`endif

/* hdl/dgc_pkg.sv */
package dgc_pkg;
    // gain loop states
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } dgc_state_type;
    // gain in units of 6 dB / 2^24
    typedef logic signed [31:0] dgc_gain_type;
endpackage

/* hdl/dgc_smp_if.sv */
`timescale 1ns/1ns
interface dgc_smp_if;
    logic signed [15:0] data;
    logic               valid;
    modport drv (output data, output valid);
    modport rcv (input data, input valid);
endinterface

/* hdl/dgc_lookahead.sv */
`timescale 1ns/1ns
`include "dgc_defines.svh"
module dgc_lookahead (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic long_in,
    input  wire logic en_in,
    // samples
    dgc_smp_if.rcv    src,
    dgc_smp_if.drv    dst
);
    logic [15:0] line_q [`DGC_LINE_LEN];

    // shift register advancing once per sample
    genvar i;
    generate
        for (i = 0; i < `DGC_LINE_LEN; i++) begin : g_tap
            if (i == 0) begin : g_head
                always_ff @(posedge clk_in or posedge rst_in) begin
                    if (rst_in) begin
                        line_q[i] <= 16'h0000;
                    end else if (src.valid) begin
                        line_q[i] <= src.data;
                    end
                end
            end else begin : g_body
                always_ff @(posedge clk_in or posedge rst_in) begin
                    if (rst_in) begin
                        line_q[i] <= 16'h0000;
                    end else if (src.valid) begin
                        line_q[i] <= line_q[i-1];
                    end
                end
            end
        end
    endgenerate

    // tap select, straight through when disabled
    wire [15:0] tap = long_in ? line_q[`DGC_TAP_LONG]
                              : line_q[`DGC_TAP_SHORT];
    assign dst.data  = en_in ? tap : src.data;
    assign dst.valid = src.valid;
endmodule

/* verif/dgc_rec_src.sv */
`timescale 1ns/1ns
// record path source: one sample every other cycle while run is high
module dgc_rec_src (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // pattern control
    input  wire logic        run_in,
    input  wire logic [1:0]  mode_in,
    // sample stream
    output logic      [15:0] data_out,
    output logic             valid_out
);
    logic [15:0] cnt_q;
    logic        ph_q;
    logic [15:0] smp_d;

    // silence, loud square, sparse spikes, single impulse
    always_comb begin
        case (mode_in)
            2'h1:    smp_d = cnt_q[0] ? 16'h9000 : 16'h7000;
            2'h2:    smp_d = (cnt_q[5:0] == 6'h00) ? 16'h7FFF : 16'h0000;
            2'h3:    smp_d = (cnt_q == 16'h0000) ? 16'h1000 : 16'h0000;
            default: smp_d = 16'h0000;
        endcase
    end

    // between samples the data line shows the inverse of the last value
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q     <= 16'h0000;
            ph_q      <= 1'b0;
            valid_out <= 1'b0;
            data_out  <= 16'h0000;
        end else if (!run_in) begin
            cnt_q     <= 16'h0000;
            ph_q      <= 1'b0;
            valid_out <= 1'b0;
            data_out  <= ~data_out;
        end else begin
            ph_q      <= ~ph_q;
            valid_out <= ~ph_q;
            data_out  <= ph_q ? ~data_out : smp_d;
            cnt_q     <= ph_q ? cnt_q : cnt_q + 16'h0001;
        end
    end
endmodule

/* verif/record_dynamic_gain_control_tb_top.sv */
`timescale 1ns/1ns
module record_dynamic_gain_control_tb_top;
    logic        clk;
    logic        rst;
    logic [7:0]  adr;
    logic        rd;
    logic        wr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        wreq;
    logic [15:0] sdi;
    logic [15:0] sdo;
    logic        svi;
    logic        svo;
    logic        run;
    logic [1:0]  mode;
    logic [31:0] gain;
    logic [31:0] gend;
    logic [15:0] q;
    logic [15:0] nz_val;
    int          first_nz;
    int          errors;
    int          check_count;
    int          cyc;
    logic [31:0] cl [4] = '{32'h02000000, 32'h03000000, 32'h04000000,
                            32'h06000000};
    logic [31:0] fl [4] = '{32'h00000000, 32'hFF000000, 32'hFE000000,
                            32'hFD000000};

    dgc_top dut (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat),
        .AVS_WAITREQUEST_OUT(wreq), .SMP_DATA_IN(sdi), .SMP_VALID_IN(svi),
        .SMP_DATA_OUT(sdo), .SMP_VALID_OUT(svo), .GAIN_OUT(gain));
    dgc_rec_src src (.clk_in(clk), .rst_in(rst), .run_in(run),
        .mode_in(mode), .data_out(sdi), .valid_out(svi));

    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // bus cycle held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr  <= a;
        wdat <= {16'h0000, d};
        rd   <= ~w;
        wr   <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 64);
        q = rdat[15:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 64) begin
            errors++;
            test_done();
        end
    endtask

    // main value: flags are look, smooth, fast, guard, hyst
    function automatic logic [15:0] mn(input logic [4:0] i,
                                       input logic [4:0] f);
        return {3'b000, 2'b01, i, f[4], 1'b0, f[3:0]};
    endfunction

    // start gain of an initial gain code, 3 dB steps from -18 dB
    function automatic int ig(input logic [4:0] i);
        return (int'(i) - 6) * 8388608;
    endfunction

    // send n samples, note first non-zero output and final gain
    task automatic run_smp(input logic [1:0] m, input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        first_nz = -1;
        @(posedge clk);
        mode <= m;
        run  <= 1'b1;
        while (k < n && t < 8 * n) begin
            @(posedge clk);
            t++;
            if (svo === 1'b1) begin
                if (sdo !== 16'h0000 && first_nz < 0) begin
                    first_nz = k;
                    nz_val   = sdo;
                end
                k++;
            end
        end
        run <= 1'b0;
        repeat (4) @(posedge clk);
        gend = gain;
    endtask

    // program with the stage off, check start gain, then enable
    task automatic cfg(input logic [15:0] m, input logic [15:0] dy,
                       input logic [4:0] i);
        bus(1'b1, 8'hA0, m);
        bus(1'b1, 8'hA4, dy);
        @(posedge clk);
        chk(gain, 32'(ig(i)));
        bus(1'b1, 8'hA0, m | 16'h8000);
    endtask

    task automatic t_regs;
        bus(1'b0, 8'hA0, 16'h0000);
        chk({16'h0000, q}, 32'h000009AF);
        bus(1'b0, 8'hA4, 16'h0000);
        chk({16'h0000, q}, 32'h00003241);
        bus(1'b1, 8'hA8, 16'hFFFF);
        bus(1'b0, 8'hA8, 16'h0000);
        chk({16'h0000, q}, 32'h00000000);
        bus(1'b1, 8'hA4, 16'hFFFF);
        bus(1'b0, 8'hA4, 16'h0000);
        chk({16'h0000, q}, 32'h0000FFFF);
        bus(1'b1, 8'hA0, 16'hFFFF);
        bus(1'b0, 8'hA0, 16'h0000);
        chk({16'h0000, q}, 32'h00009FEF);
        bus(1'b1, 8'hA0, 16'h09AF);
        bus(1'b1, 8'hA4, 16'h3241);
    endtask

    task automatic t_delay;
        run_smp(2'd3, 9); // impulse must leave the line
        chk(32'(first_nz), 32'h0);
        chk({16'h0000, nz_val}, 32'h00001000);
        cfg(mn(5'd6, 5'h12), 16'h3241, 5'd6);
        run_smp(2'd3, 12);
        chk(32'(first_nz), 32'h9);
        cfg(mn(5'd6, 5'h02), 16'h3241, 5'd6);
        run_smp(2'd3, 12);
        chk(32'(first_nz), 32'h5);
        cfg(mn(5'd6, 5'h10), 16'h3241, 5'd6);
        run_smp(2'd3, 12);
        chk(32'(first_nz), 32'h0);
    endtask

    task automatic t_limits;
        logic ok;
        for (int c = 0; c < 4; c++) begin
            cfg(mn(5'd18, 5'h00), {12'h304, 2'h3, 2'(c)}, 5'd18);
            run_smp(2'd0, 8);
            chk(gend, cl[c]);
            cfg(mn(5'd0, 5'h00), {12'h304, 2'(c), 2'h3}, 5'd0);
            run_smp(2'd0, 8);
            ok = $signed(gend) >= $signed(fl[c]) &&
                 $signed(gend) <= $signed(fl[c]) + 16000;
            chk({31'h0, ok}, 32'h1);
        end
    endtask

    // gain change over n samples lies between lo and n steps of time t
    task automatic rate(input logic [15:0] dy, input logic [4:0] f,
                        input logic [4:0] i, input logic [1:0] m,
                        input int n, input longint t, input logic up,
                        input longint lo);
        longint d;
        longint hi;
        logic   ok;
        cfg(mn(i, f), dy, i);
        run_smp(m, n);
        d  = longint'($signed(gend)) - ig(i);
        d  = up ? d : -d;
        hi = longint'(n) * 64'd16777216000000000 / (t * 64'd48000);
        ok = d > lo && d <= hi;
        chk({31'h0, ok}, 32'h1);
    endtask

    initial begin
        clk  = 1'b0;
        rst  = 1'b1;
        adr  = 8'h00;
        rd   = 1'b0;
        wr   = 1'b0;
        wdat = 32'h00000000;
        run  = 1'b0;
        mode = 2'h0;
        cyc  = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_delay();
        t_limits();
        rate(16'h124F, 5'h00, 5'd18, 2'd1, 16, 182000, 1'b0, 60262);
        rate(16'hA24F, 5'h00, 5'd18, 2'd1, 16, 92800000, 1'b0, 0);
        rate(16'hF24F, 5'h00, 5'd18, 2'd1, 16, 92800000, 1'b0, 0);
        rate(16'h024F, 5'h00, 5'd18, 2'd1, 16, 182000, 1'b0, 60262);
        rate(16'h304F, 5'h00, 5'd6, 2'd0, 32, 186000000, 1'b1, 0);
        rate(16'h384F, 5'h00, 5'd6, 2'd0, 32, 64'd47560000000, 1'b1, 0);
        rate(16'h3F4F, 5'h00, 5'd6, 2'd0, 32, 64'd47560000000, 1'b1, 0);
        rate(16'h380F, 5'h04, 5'd6, 2'd2, 128, 725000, 1'b1, 941);
        rate(16'h380F, 5'h00, 5'd6, 2'd2, 128, 64'd47560000000, 1'b1, 0);
        rate(16'hA24F, 5'h02, 5'd18, 2'd1, 16, 23200000, 1'b0, 60262);
        rate(16'h304F, 5'h08, 5'd6, 2'd0, 32, 280000000, 1'b1, 30000);
        rate(16'h304F, 5'h01, 5'd6, 2'd1, 16, 186000000, 1'b1, 0);
        test_done();
    end
endmodule
